/* File: clock_generator_config_pkg.sv */
// Constants and types shared by the clock generator configuration block.
package clock_generator_config_pkg;

    // Bank size and field widths.
    localparam int NGEN      = 9;
    localparam int IDX_W     = 4;
    localparam int SRC_W     = 5;
    localparam int FACT_W    = 16;
    localparam int CNT_W     = FACT_W + 2;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 32;
    localparam int BE_W      = 4;
    localparam int EXT_SRC_N = 8;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] CTRL_OFFSET = 8'h04;
    localparam logic [ADDR_W-1:0] DIV_OFFSET  = 8'h08;

    // Field positions.
    localparam int IDX_LSB      = 0;
    localparam int SEL_LSB      = 8;
    localparam int FACT_LSB     = 8;
    localparam int ON_BIT       = 16;
    localparam int DUTY_BIT     = 17;
    localparam int OFF_VAL_BIT  = 18;
    localparam int OUT_EN_BIT   = 19;
    localparam int DIVMODE_BIT  = 20;
    localparam int RUN_STBY_BIT = 21;

    // Generator indices.
    localparam logic [IDX_W-1:0] GEN_LAST = 4'h8;

    // Source codes.
    localparam logic [SRC_W-1:0] SOURCE_CRYSTAL_OSCILLATOR   = 5'h00;
    localparam logic [SRC_W-1:0] SOURCE_GENERATOR_INPUT_PAD  = 5'h01;
    localparam logic [SRC_W-1:0] SOURCE_GENERATOR_ONE_OUTPUT = 5'h02;
    localparam logic [SRC_W-1:0] SOURCE_ULTRA_LOW_POWER_32K  = 5'h03;
    localparam logic [SRC_W-1:0] SOURCE_INTERNAL_32K         = 5'h04;
    localparam logic [SRC_W-1:0] SOURCE_EXTERNAL_32K_CRYSTAL = 5'h05;
    localparam logic [SRC_W-1:0] SOURCE_INTERNAL_8MHZ        = 5'h06;
    localparam logic [SRC_W-1:0] SOURCE_LOCKED_LOOP_48MHZ    = 5'h07;
    localparam logic [SRC_W-1:0] SOURCE_PLL_96MHZ            = 5'h08;

    // Reset values.
    localparam logic [DATA_W-1:0] CTRL_POWER_RST_GEN0 = 32'h00010600;
    localparam logic [DATA_W-1:0] CTRL_POWER_RST_GEN2 = 32'h00010302;
    localparam logic [DATA_W-1:0] CTRL_POWER_RST_REST = 32'h00000000;
    localparam logic [FACT_W-1:0] DIV_POWER_RST       = 16'h0000;

    // Implemented factor bits per generator.
    localparam logic [FACT_W-1:0] FACT_MASK_GEN1    = 16'hffff;
    localparam logic [FACT_W-1:0] FACT_MASK_GEN2    = 16'h001f;
    localparam logic [FACT_W-1:0] FACT_MASK_DEFAULT = 16'h00ff;

    // Largest factor whose value plus one is the exponent in power-of-two mode; larger factors give the largest exponent, 16.
    localparam logic [FACT_W-1:0] MAX_SHIFT = 16'h000f;

    typedef struct packed {
        logic             run_stby;
        logic             divide_mode;
        logic             out_en;
        logic             out_off_value;
        logic             duty_fix;
        logic             generator_on;
        logic [SRC_W-1:0] source_select;
    } gen_ctrl_t;

endpackage

/* File: clock_generator_config.sv */
// Register views and divider logic for a bank of nine clock generators.
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps

module clock_generator_config (
    // Clock and resets.
    input  wire logic                                                 i_clk,
    input  wire logic                                                 i_reset,
    input  wire logic                                                 i_user_reset,
    // Register port.
    input  wire logic [clock_generator_config_pkg::ADDR_W-1:0]        i_addr,
    input  wire logic [clock_generator_config_pkg::DATA_W-1:0]        i_wdata,
    input  wire logic [clock_generator_config_pkg::BE_W-1:0]          i_wr_be,
    input  wire logic                                                 i_wr,
    input  wire logic                                                 i_rd,
    output logic      [clock_generator_config_pkg::DATA_W-1:0]        o_rdata,
    // Consumer status per generator.
    input  wire logic [clock_generator_config_pkg::NGEN-1:0]          i_feeds_write_lock,
    input  wire logic [clock_generator_config_pkg::NGEN-1:0]          i_feeds_rtc,
    // Source clock edges, one pulse per edge of each source.
    input  wire logic [clock_generator_config_pkg::EXT_SRC_N-1:0]     i_src_edge,
    // Generator outputs.
    output logic      [clock_generator_config_pkg::NGEN-1:0]          o_gen_clk,
    output logic      [clock_generator_config_pkg::NGEN-1:0]          o_gen_active
);
    import clock_generator_config_pkg::*;

    typedef struct packed {
        logic [IDX_W-1:0]                 ctrl_index;
        logic [IDX_W-1:0]                 div_index;
        gen_ctrl_t [NGEN-1:0]             ctrl;
        logic [NGEN-1:0][FACT_W-1:0]      factor;
        logic [NGEN-1:0][CNT_W-1:0]       edge_cnt;
        logic [NGEN-1:0]                  level;
        logic [NGEN-1:0]                  level_edge;
        logic [NGEN-1:0]                  active;
        logic [DATA_W-1:0]                rdata;
    } state_t;

    state_t                 st_ff;
    state_t                 nxt_st;

    logic [IDX_W-1:0]       tgt;
    logic [FACT_W:0]        period_n;
    logic [FACT_W:0]        high_n;
    logic                   src_edge;
    logic                   run;
    logic                   keep;
    logic [FACT_W-1:0]      fmask_w;

    // Unpacks a full control word into stored fields.
    function automatic gen_ctrl_t word_to_ctrl(input logic [DATA_W-1:0] w);
        gen_ctrl_t c;
        c.run_stby      = w[RUN_STBY_BIT];
        c.divide_mode   = w[DIVMODE_BIT];
        c.out_en        = w[OUT_EN_BIT];
        c.out_off_value = w[OFF_VAL_BIT];
        c.duty_fix      = w[DUTY_BIT];
        c.generator_on  = w[ON_BIT];
        c.source_select = w[SEL_LSB +: SRC_W];
        return c;
    endfunction

    // Power-on control settings of one generator.
    function automatic gen_ctrl_t ctrl_default(input int g);
        gen_ctrl_t c;
        if (g == 0) begin
            c = word_to_ctrl(CTRL_POWER_RST_GEN0);
        end else if (g == 2) begin
            c = word_to_ctrl(CTRL_POWER_RST_GEN2);
        end else begin
            c = word_to_ctrl(CTRL_POWER_RST_REST);
        end
        return c;
    endfunction

    // Writable factor bits of one generator.
    function automatic logic [FACT_W-1:0] fact_mask(input logic [IDX_W-1:0] g);
        logic [FACT_W-1:0] m;
        if (g == 4'h1) begin
            m = FACT_MASK_GEN1;
        end else if (g == 4'h2) begin
            m = FACT_MASK_GEN2;
        end else begin
            m = FACT_MASK_DEFAULT;
        end
        return m;
    endfunction

    // Read-back word of the control view.
    function automatic logic [DATA_W-1:0] ctrl_word(input logic [IDX_W-1:0] idx,
                                                    input gen_ctrl_t     c);
        logic [DATA_W-1:0] w;
        w                      = '0;
        w[IDX_LSB +: IDX_W]    = idx;
        w[SEL_LSB +: SRC_W]    = c.source_select;
        w[ON_BIT]              = c.generator_on;
        w[DUTY_BIT]            = c.duty_fix;
        w[OFF_VAL_BIT]         = c.out_off_value;
        w[OUT_EN_BIT]          = c.out_en;
        w[DIVMODE_BIT]         = c.divide_mode;
        w[RUN_STBY_BIT]        = c.run_stby;
        return w;
    endfunction

    // Number of source periods in one output period.
    function automatic logic [FACT_W:0] period(input logic [FACT_W-1:0] f,
                                               input logic              m);
        logic [FACT_W:0] r;
        logic [4:0]      e;
        e = (f > MAX_SHIFT) ? 5'h10 : (f[4:0] + 5'h01);
        if (m) begin
            r = {{FACT_W{1'b0}}, 1'b1} << e;
        end else if (f <= 16'h0001) begin
            r = {{FACT_W{1'b0}}, 1'b1};
        end else begin
            r = {1'b0, f};
        end
        return r;
    endfunction

    // Picks the edge stream of the selected source.
    function automatic logic source_edge(input logic [SRC_W-1:0]     s,
                                         input logic [EXT_SRC_N-1:0] ext,
                                         input logic                 gen_one_edge);
        logic       r;
        logic [4:0] k;
        r = 1'b0;
        k = 5'h00;
        if (s == SOURCE_GENERATOR_ONE_OUTPUT) begin
            r = gen_one_edge;
        end else if (s < SOURCE_GENERATOR_ONE_OUTPUT) begin
            r = ext[s[2:0]];
        end else if (s <= SOURCE_PLL_96MHZ) begin
            k = s - 5'h01;
            r = ext[k[2:0]];
        end
        return r;
    endfunction

    always_comb begin
        nxt_st   = st_ff;
        tgt      = '0;
        period_n = '0;
        high_n   = '0;
        src_edge = 1'b0;
        run      = 1'b0;
        keep     = 1'b0;
        fmask_w  = '0;
        nxt_st.rdata = '0;

        // Read data stand for exactly the cycle after the strobe.
        if (i_rd) begin
            if (i_addr == CTRL_OFFSET) begin
                if (st_ff.ctrl_index <= GEN_LAST) begin
                    nxt_st.rdata = ctrl_word(st_ff.ctrl_index,
                                             st_ff.ctrl[st_ff.ctrl_index]);
                end else begin
                    nxt_st.rdata = ctrl_word(st_ff.ctrl_index, '0);
                end
            end else if (i_addr == DIV_OFFSET) begin
                nxt_st.rdata[IDX_LSB +: IDX_W] = st_ff.div_index;
                if (st_ff.div_index <= GEN_LAST) begin
                    nxt_st.rdata[FACT_LSB +: FACT_W] = st_ff.factor[st_ff.div_index];
                end
            end
        end

        // A low-byte write moves the index; bytes 1 and 2 update the addressed entry.
        if (i_wr && (i_addr == CTRL_OFFSET)) begin
            tgt = i_wr_be[0] ? i_wdata[IDX_LSB +: IDX_W] : st_ff.ctrl_index;
            if (i_wr_be[0]) begin
                nxt_st.ctrl_index = i_wdata[IDX_LSB +: IDX_W];
            end
            if (tgt <= GEN_LAST) begin
                if (i_wr_be[1]) begin
                    nxt_st.ctrl[tgt].source_select = i_wdata[SEL_LSB +: SRC_W];
                end
                if (i_wr_be[2]) begin
                    nxt_st.ctrl[tgt].generator_on  = i_wdata[ON_BIT];
                    nxt_st.ctrl[tgt].duty_fix      = i_wdata[DUTY_BIT];
                    nxt_st.ctrl[tgt].out_off_value = i_wdata[OFF_VAL_BIT];
                    nxt_st.ctrl[tgt].out_en        = i_wdata[OUT_EN_BIT];
                    nxt_st.ctrl[tgt].divide_mode   = i_wdata[DIVMODE_BIT];
                    nxt_st.ctrl[tgt].run_stby      = i_wdata[RUN_STBY_BIT];
                end
            end
        end else if (i_wr && (i_addr == DIV_OFFSET)) begin
            tgt = i_wr_be[0] ? i_wdata[IDX_LSB +: IDX_W] : st_ff.div_index;
            fmask_w = fact_mask(tgt);
            if (i_wr_be[0]) begin
                nxt_st.div_index = i_wdata[IDX_LSB +: IDX_W];
            end
            if (tgt <= GEN_LAST) begin
                if (i_wr_be[1]) begin
                    nxt_st.factor[tgt][7:0] = i_wdata[FACT_LSB +: 8] & fmask_w[7:0];
                end
                if (i_wr_be[2]) begin
                    nxt_st.factor[tgt][15:8] = i_wdata[FACT_LSB + 8 +: 8]
                                               & fmask_w[15:8];
                end
            end
        end

        // Each divider counts source edges: two edges make one source period.
        for (int g = 0; g < NGEN; g++) begin
            period_n = period(st_ff.factor[g], st_ff.ctrl[g].divide_mode);
            if (st_ff.ctrl[g].duty_fix || !period_n[0] || (period_n == 17'h00001)) begin
                high_n = period_n;
            end else begin
                high_n = period_n - 17'h00001;
            end
            src_edge = source_edge(st_ff.ctrl[g].source_select, i_src_edge,
                                   st_ff.level_edge[1]);
            run = st_ff.ctrl[g].generator_on
                  && (st_ff.ctrl[g].source_select <= SOURCE_PLL_96MHZ);
            nxt_st.active[g]     = run;
            nxt_st.level_edge[g] = 1'b0;
            if (!run) begin
                nxt_st.edge_cnt[g] = '0;
                nxt_st.level[g]    = 1'b0;
            end else if (src_edge) begin
                nxt_st.level[g] = (st_ff.edge_cnt[g] < {1'b0, high_n});
                if (st_ff.edge_cnt[g] >= ({period_n, 1'b0} - 18'h00001)) begin
                    nxt_st.edge_cnt[g] = '0;
                end else begin
                    nxt_st.edge_cnt[g] = st_ff.edge_cnt[g] + 18'h00001;
                end
                nxt_st.level_edge[g] = (nxt_st.level[g] != st_ff.level[g]);
            end
        end

        // Power reset restores everything; user reset spares protected generators other than generator 0.
        if (i_reset) begin
            nxt_st.ctrl_index = '0;
            nxt_st.div_index  = '0;
            nxt_st.rdata      = '0;
            for (int g = 0; g < NGEN; g++) begin
                nxt_st.ctrl[g]       = ctrl_default(g);
                nxt_st.factor[g]     = DIV_POWER_RST;
                nxt_st.edge_cnt[g]   = '0;
                nxt_st.level[g]      = 1'b0;
                nxt_st.level_edge[g] = 1'b0;
                nxt_st.active[g]     = 1'b0;
            end
        end else if (i_user_reset) begin
            nxt_st.ctrl_index = '0;
            nxt_st.div_index  = '0;
            nxt_st.rdata      = '0;
            for (int g = 0; g < NGEN; g++) begin
                keep = (g != 0) && (i_feeds_write_lock[g] || i_feeds_rtc[g]);
                if (!keep) begin
                    nxt_st.ctrl[g]       = ctrl_default(g);
                    nxt_st.factor[g]     = DIV_POWER_RST;
                    nxt_st.edge_cnt[g]   = '0;
                    nxt_st.level[g]      = 1'b0;
                    nxt_st.level_edge[g] = 1'b0;
                    nxt_st.active[g]     = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        st_ff <= nxt_st;
    end

    assign o_rdata      = st_ff.rdata;
    assign o_gen_clk    = st_ff.level;
    assign o_gen_active = st_ff.active;

endmodule

/* File: clock_generator_config_monitor.sv */
// Concurrent checks on the register port and generator outputs of the configuration block.
`timescale 1ns/1ps

module clock_generator_config_monitor (
    // Clock and resets.
    input wire logic        i_clk,
    input wire logic        i_reset,
    input wire logic        i_user_reset,
    // Register port.
    input wire logic [7:0]  i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0]  i_wr_be,
    input wire logic        i_wr,
    input wire logic        i_rd,
    input wire logic [31:0] o_rdata,
    // Consumer status and sources.
    input wire logic [8:0]  i_feeds_write_lock,
    input wire logic [8:0]  i_feeds_rtc,
    input wire logic [7:0]  i_src_edge,
    // Generator outputs.
    input wire logic [8:0]  o_gen_clk,
    input wire logic [8:0]  o_gen_active
);
    import clock_generator_config_pkg::*;

    logic [31:0] w1_data_ff;
    logic [31:0] w2_data_ff;
    logic        ctrl_wr;

    assign ctrl_wr = i_wr && i_addr == CTRL_OFFSET && i_wr_be == 4'hf && !i_user_reset;

    // Write data two cycles back, so a reply or a status can be tied to the write behind it.
    always_ff @(posedge i_clk) begin
        w1_data_ff <= i_wdata;
        w2_data_ff <= w1_data_ff;
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);

    chk_rdata_idle: assert property (!i_rd |=> o_rdata == 32'h0)
        else $error("read data not zero outside a read reply");
    chk_ctrl_reserved: assert property (
        i_rd && i_addr == CTRL_OFFSET |=> (o_rdata & 32'hffc0e0f0) == 32'h0)
        else $error("control view reserved bits not zero");
    chk_div_reserved: assert property (
        i_rd && i_addr == DIV_OFFSET |=> (o_rdata & 32'hff0000f0) == 32'h0)
        else $error("division view reserved bits not zero");
    chk_unmapped_zero: assert property (
        i_rd && i_addr != CTRL_OFFSET && i_addr != DIV_OFFSET |=> o_rdata == 32'h0)
        else $error("unmapped read not zero");
    chk_ctrl_readback: assert property (
        ctrl_wr && i_wdata[3:0] <= GEN_LAST ##1 i_rd && i_addr == CTRL_OFFSET && !i_user_reset
        |=> o_rdata == (w2_data_ff & 32'h003f1f0f))
        else $error("control readback differs from the write before it");
    chk_active_cfg: assert property (
        ctrl_wr && i_wdata[3:0] <= GEN_LAST ##1 !i_wr && !i_user_reset
        |=> o_gen_active[w2_data_ff[3:0]] == (w2_data_ff[16] && w2_data_ff[12:8] <= 5'h08))
        else $error("generator activity does not follow its enable and source");
    chk_clk_gated: assert property (
        ((~o_gen_active & ~$past(o_gen_active)) & o_gen_clk) == 9'h0)
        else $error("inactive generator drives its clock");
    chk_power_on: assert property (
        $fell(i_reset) && !i_user_reset |-> ##[0:2] o_gen_active == 9'h005)
        else $error("generators 0 and 2 not running after power reset");
    chk_user_gen0: assert property ($fell(i_user_reset) |-> ##[0:2] o_gen_active[0])
        else $error("generator 0 not running after user reset");
endmodule

bind clock_generator_config clock_generator_config_monitor clock_generator_config_monitor_i (
    .i_clk(i_clk), .i_reset(i_reset), .i_user_reset(i_user_reset), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr_be(i_wr_be), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_feeds_write_lock(i_feeds_write_lock), .i_feeds_rtc(i_feeds_rtc),
    .i_src_edge(i_src_edge), .o_gen_clk(o_gen_clk), .o_gen_active(o_gen_active));

/* File: clock_generator_config_tb_top.sv */
// Self-checking testbench for the clock generator configuration block.
`timescale 1ns/1ps

module clock_generator_config_tb_top;
    import clock_generator_config_pkg::*;

    logic        i_clk              = 1'b0;
    logic        i_reset            = 1'b1;
    logic        i_user_reset       = 1'b0;
    logic [7:0]  i_addr             = 8'h00;
    logic [31:0] i_wdata            = 32'h0;
    logic [3:0]  i_wr_be            = 4'h0;
    logic        i_wr               = 1'b0;
    logic        i_rd               = 1'b0;
    logic [8:0]  i_feeds_write_lock = 9'h000;
    logic [8:0]  i_feeds_rtc        = 9'h000;
    logic [7:0]  i_src_edge         = 8'h00;
    logic [31:0] o_rdata;
    logic [8:0]  o_gen_clk;
    logic [8:0]  o_gen_active;
    int          fail_count         = 0;
    int          n_tests            = 0;

    always #5 i_clk = ~i_clk;

    clock_generator_config clock_generator_config_i (
        .i_clk(i_clk), .i_reset(i_reset), .i_user_reset(i_user_reset), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr_be(i_wr_be), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_feeds_write_lock(i_feeds_write_lock), .i_feeds_rtc(i_feeds_rtc),
        .i_src_edge(i_src_edge), .o_gen_clk(o_gen_clk), .o_gen_active(o_gen_active));

    task automatic report_and_stop();
        if (fail_count == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask

    // Ends at the taking edge with the strobe dropped; a read may follow at once.
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_be <= be;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(what, exp, o_rdata);
        @(posedge i_clk);
    endtask

    function automatic logic [31:0] dflt(input int g);
        return (g == 0) ? CTRL_POWER_RST_GEN0 : (g == 2) ? CTRL_POWER_RST_GEN2 : 32'(g);
    endfunction

    function automatic logic [15:0] fmask(input int g);
        return (g == 1) ? 16'hffff : (g == 2) ? 16'h001f : (g > 8) ? 16'h0000 : 16'h00ff;
    endfunction

    // Counts high cycles of generator 5 over two output periods after two periods of warm-up.
    task automatic divtest(input logic [31:0] ctl, input logic [15:0] f, input int pe,
                           input int hi);
        int cnt;
        cnt = 0;
        wr(DIV_OFFSET, 4'hf, {8'h00, f, 8'h05});
        @(posedge i_clk);
        wr(CTRL_OFFSET, 4'hf, ctl);
        for (int k = 0; k < 8 * pe; k++) begin
            i_src_edge <= (k % 2 == 0) ? 8'h04 : 8'h00;
            @(posedge i_clk);
            #1;
            if (k >= 4 * pe) cnt += int'(o_gen_clk[5]);
        end
        i_src_edge <= 8'h00;
        chk("divided clock high cycles", 32'(4 * hi), 32'(cnt));
    endtask

    initial begin
        repeat (20000) @(posedge i_clk);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (5) @(posedge i_clk);
        i_reset <= 1'b0;
        repeat (3) @(posedge i_clk);
        chk("active after power reset", 32'h5, {23'h0, o_gen_active});
        for (int g = 0; g < 9; g++) begin
            wr(CTRL_OFFSET, 4'h1, 32'(g));
            rd(CTRL_OFFSET, dflt(g), "control after power reset");
            wr(DIV_OFFSET, 4'h1, 32'(g));
            rd(DIV_OFFSET, 32'(g), "division after power reset");
        end
        for (int s = 0; s < 32; s++) begin
            wr(CTRL_OFFSET, 4'hf, 32'h00020005 | {15'h0, s[0], 3'h0, s[4:0], 8'h0});
            rd(CTRL_OFFSET, 32'h00020005 | {15'h0, s[0], 3'h0, s[4:0], 8'h0}, "source");
            chk("active for source", {31'h0, s[0] && s < 9}, {31'h0, o_gen_active[5]});
        end
        divtest(32'h00010305, 16'h0000, 2, 1);
        divtest(32'h00010305, 16'h0003, 6, 2);
        divtest(32'h00030305, 16'h0003, 6, 3);
        divtest(32'h00110305, 16'h0001, 8, 4);
        for (int g = 0; g < 10; g++) begin
            wr(DIV_OFFSET, 4'hf, 32'h00ffff00 | 32'(g));
            @(posedge i_clk);
        end
        for (int g = 0; g < 10; g++) begin
            wr(DIV_OFFSET, 4'h1, 32'(g));
            rd(DIV_OFFSET, {8'h0, fmask(g), 8'h0} | 32'(g), "factor width");
        end
        wr(CTRL_OFFSET, 4'h1, 32'h9);
        rd(CTRL_OFFSET, 32'h9, "reserved index");
        rd(8'h0c, 32'h0, "unmapped read");
        i_feeds_write_lock <= 9'h00a;
        i_feeds_rtc <= 9'h011;
        for (int g = 0; g < 9; g++) begin
            wr(CTRL_OFFSET, 4'hf, 32'h00010100 | 32'(g));
            @(posedge i_clk);
        end
        i_user_reset <= 1'b1;
        @(posedge i_clk);
        i_user_reset <= 1'b0;
        for (int g = 0; g < 9; g++) begin
            logic        keep;
            logic [31:0] ec;
            logic [31:0] ed;
            keep = g != 0 && (i_feeds_write_lock[g] || i_feeds_rtc[g]);
            ec = keep ? 32'h00010100 | 32'(g) : dflt(g);
            ed = keep ? {8'h0, fmask(g), 8'h0} | 32'(g) : 32'(g);
            wr(CTRL_OFFSET, 4'h1, 32'(g));
            rd(CTRL_OFFSET, ec, "user reset ctrl");
            wr(DIV_OFFSET, 4'h1, 32'(g));
            rd(DIV_OFFSET, ed, "user reset div");
        end
        i_reset <= 1'b1;
        repeat (2) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        wr(CTRL_OFFSET, 4'h1, 32'h4);
        rd(CTRL_OFFSET, 32'h4, "rtc generator after power reset");
        wr(CTRL_OFFSET, 4'h1, 32'h1);
        rd(CTRL_OFFSET, 32'h1, "locked generator after power reset");
        report_and_stop();
    end
endmodule
